/* File: rolling_peak_demand.sv */
// Rolling and peak demand of three phase currents
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "rpd_defs.svh"
module rolling_peak_demand
  import rpd_pkg::*;
#(
  parameter int unsigned MIN_CYC = `RPD_MIN_CYC,
  parameter int          RMS_W   = `RPD_RMS_W,
  parameter int          CNT_W   = `RPD_CNT_W
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  busAddr,
  input  wire logic [31:0] busWdata,
  input  wire logic        busWr,
  input  wire logic        busRd,
  output logic [31:0]      busRdata,
  input  wire rpd_rms_t    rmsIn,
  input  wire logic        keyReset,
  input  wire rpd_demand_t nvPeak,
  output rpd_demand_t      rollOut,
  output rpd_demand_t      peakOut,
  output logic             rollValid
);
  localparam int SUM_W = RMS_W + CNT_W;
  localparam int NW    = `RPD_NSUB_W;
  localparam int MW    = `RPD_MIN_W;
  localparam int NMAX  = `RPD_NSUB_MAX;

  rpd_state_t           state_reg;
  logic [MW-1:0]        subMin_reg;
  logic [NW-1:0]        nSub_reg;
  logic [31:0]          tickCnt_reg;
  logic [MW-1:0]        minCnt_reg;
  logic [NW-1:0]        fill_reg;
  logic [NW-1:0]        ptr_reg;
  logic [CNT_W-1:0]     sampCnt_reg;
  logic                 keySync1_reg;
  logic                 keySync2_reg;
  logic                 keySync3_reg;
  logic                 restored_reg;
  logic                 rollValid_reg;
  logic [31:0]          busRdata_reg;
  rpd_demand_t          rollOut_reg;
  rpd_demand_t          peak_reg;
  logic                 minuteTick;
  logic                 subEnd;
  logic                 keyEdge;
  logic                 remoteReset;
  logic                 ctrlWr;
  logic                 ctrlOk;
  logic [MW-1:0]        newMin;
  logic [NW-1:0]        newN;
  logic                 minChange;
  logic                 restartRoll;
  logic                 clearPeak;
  logic                 divStart;
  logic                 fillsNow;
  logic [2:0]           divDone;
  logic [2:0]           divBusy;
  logic [CNT_W-1:0]     avgDen;

  // Front key pin is asynchronous: two stages, then an edge stage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      keySync1_reg <= 1'b0;
      keySync2_reg <= 1'b0;
      keySync3_reg <= 1'b0;
    end else begin
      keySync1_reg <= keyReset;
      keySync2_reg <= keySync1_reg;
      keySync3_reg <= keySync2_reg;
    end
  end

  assign keyEdge     = keySync2_reg & ~keySync3_reg;
  assign remoteReset = busWr && busAddr == `RPD_OFF_CMD && busWdata[`RPD_CMD_RESET];
  assign newMin      = busWdata[`RPD_CTRL_MIN_LSB +: MW];
  assign newN        = busWdata[`RPD_CTRL_N_LSB +: NW];
  assign ctrlWr      = busWr && busAddr == `RPD_OFF_CTRL;
  // Out-of-range settings are refused whole
  assign ctrlOk      = ctrlWr && newMin != '0 && newMin <= MW'(`RPD_SUBMIN_MAX)
                       && newN != '0 && newN <= NW'(NMAX);
  assign minChange   = ctrlOk && newMin != subMin_reg;
  assign restartRoll = keyEdge || remoteReset || minChange || (ctrlOk && newN != nSub_reg);
  assign clearPeak   = keyEdge || remoteReset || minChange;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      subMin_reg <= `RPD_RST_SUBMIN;
      nSub_reg   <= `RPD_RST_NSUB;
    end else if (ctrlOk) begin
      subMin_reg <= newMin;
      nSub_reg   <= newN;
    end
  end

  // Minute time base restarts together with the calculation
  assign minuteTick = tickCnt_reg == MIN_CYC - 32'd1;
  assign subEnd     = minuteTick && minCnt_reg == subMin_reg - MW'(1);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt_reg <= '0;
      minCnt_reg  <= '0;
    end else if (restartRoll) begin
      tickCnt_reg <= '0;
      minCnt_reg  <= '0;
    end else if (minuteTick) begin
      tickCnt_reg <= '0;
      minCnt_reg  <= subEnd ? '0 : minCnt_reg + MW'(1);
    end else begin
      tickCnt_reg <= tickCnt_reg + 32'd1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sampCnt_reg <= '0;
    end else if (restartRoll || subEnd) begin
      sampCnt_reg <= rmsIn.valid && !restartRoll ? CNT_W'(1) : '0;
    end else if (rmsIn.valid && sampCnt_reg != '1) begin
      sampCnt_reg <= sampCnt_reg + CNT_W'(1);
    end
  end

  assign avgDen   = sampCnt_reg == '0 ? CNT_W'(1) : sampCnt_reg;
  assign fillsNow = fill_reg >= nSub_reg - NW'(1);
  assign divStart = (state_reg == ST_IDLE && subEnd && !restartRoll)
                    || (state_reg == ST_UPD && fillsNow && !restartRoll);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
    end else if (restartRoll) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: if (subEnd) begin
          state_reg <= ST_AVG;
        end
        ST_AVG: if (divDone[0]) begin
          state_reg <= ST_UPD;
        end
        ST_UPD: state_reg <= fillsNow ? ST_ROLL : ST_IDLE;
        ST_ROLL: if (divDone[0]) begin
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Window fill and write pointer; lost on reset like all rolling state
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fill_reg <= '0;
      ptr_reg  <= '0;
    end else if (restartRoll) begin
      fill_reg <= '0;
      ptr_reg  <= '0;
    end else if (state_reg == ST_UPD) begin
      if (fill_reg != nSub_reg) begin
        fill_reg <= fill_reg + NW'(1);
      end
      ptr_reg <= ptr_reg == nSub_reg - NW'(1) ? '0 : ptr_reg + NW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rollValid_reg <= 1'b0;
    end else if (restartRoll) begin
      rollValid_reg <= 1'b0;
    end else if (state_reg == ST_ROLL && divDone[0]) begin
      rollValid_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      restored_reg <= 1'b0;
    end else begin
      restored_reg <= 1'b1;
    end
  end

  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++) begin : g_phase
      logic [SUM_W-1:0]      acc_reg;
      logic [RMS_W+NW-1:0]   winSum_reg;
      logic [RMS_W-1:0]      win_reg [NMAX];
      logic [RMS_W+NW-1:0]   winSumNext;
      logic [SUM_W-1:0]      divNum;
      logic [CNT_W-1:0]      divDen;
      logic [SUM_W-1:0]      divQuo;
      logic [RMS_W-1:0]      newAvg;
      logic [RMS_W-1:0]      oldest;

      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          acc_reg <= '0;
        end else if (restartRoll || subEnd) begin
          acc_reg <= rmsIn.valid && !restartRoll ? SUM_W'(rmsIn.phaseCurrent[ph]) : '0;
        end else if (rmsIn.valid) begin
          acc_reg <= acc_reg + SUM_W'(rmsIn.phaseCurrent[ph]);
        end
      end

      assign newAvg     = divQuo[RMS_W-1:0];
      assign oldest     = fill_reg == nSub_reg ? win_reg[ptr_reg] : '0;
      assign winSumNext = winSum_reg + (RMS_W+NW)'(newAvg) - (RMS_W+NW)'(oldest);
      assign divNum     = state_reg == ST_UPD ? SUM_W'(winSumNext) : acc_reg;
      assign divDen     = state_reg == ST_UPD ? CNT_W'(nSub_reg) : avgDen;

      rpd_divider #(
        .NW (SUM_W),
        .DW (CNT_W)
      ) u_div (
        .clk    (core_clk),
        .arst_n (arst_n),
        .start  (divStart),
        .num    (divNum),
        .den    (divDen),
        .busy   (divBusy[ph]),
        .done   (divDone[ph]),
        .quo    (divQuo)
      );

      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          winSum_reg <= '0;
        end else if (restartRoll) begin
          winSum_reg <= '0;
        end else if (state_reg == ST_UPD) begin
          winSum_reg <= winSumNext;
        end
      end

      always_ff @(posedge core_clk) begin
        if (state_reg == ST_UPD && !restartRoll) begin
          win_reg[ptr_reg] <= newAvg;
        end
      end

      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          rollOut_reg.val[ph] <= '0;
        end else if (restartRoll) begin
          rollOut_reg.val[ph] <= '0;
        end else if (state_reg == ST_ROLL && divDone[ph]) begin
          rollOut_reg.val[ph] <= divQuo[RMS_W-1:0];
        end
      end

      // Peak is reloaded from the backing store after reset
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          peak_reg.val[ph] <= '0;
        end else if (clearPeak) begin
          peak_reg.val[ph] <= '0;
        end else if (!restored_reg) begin
          peak_reg.val[ph] <= nvPeak.val[ph];
        end else if (state_reg == ST_UPD && newAvg > peak_reg.val[ph]) begin
          peak_reg.val[ph] <= newAvg;
        end
      end

      property p_peak_mono;
        @(posedge core_clk) disable iff (!arst_n)
          restored_reg && !clearPeak |=> peak_reg.val[ph] >= $past(peak_reg.val[ph]);
      endproperty
      a_peak_mono: assert property (p_peak_mono) else $error("peak value decreased without a clear");
    end
  endgenerate

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busRdata_reg <= '0;
    end else if (busRd) begin
      case (busAddr)
        `RPD_OFF_CTRL:        busRdata_reg <= {19'h0, nSub_reg, 2'h0, subMin_reg};
        `RPD_OFF_STATUS:      busRdata_reg <= {19'h0, fill_reg, 6'h0, (state_reg != ST_IDLE || divBusy != 3'h0),
                                               rollValid_reg};
        `RPD_OFF_ROLL_A:      busRdata_reg <= {16'h0, rollOut_reg.val[0]};
        `RPD_OFF_ROLL_A + 4:  busRdata_reg <= {16'h0, rollOut_reg.val[1]};
        `RPD_OFF_ROLL_A + 8:  busRdata_reg <= {16'h0, rollOut_reg.val[2]};
        `RPD_OFF_PEAK_A:      busRdata_reg <= {16'h0, peak_reg.val[0]};
        `RPD_OFF_PEAK_A + 4:  busRdata_reg <= {16'h0, peak_reg.val[1]};
        `RPD_OFF_PEAK_A + 8:  busRdata_reg <= {16'h0, peak_reg.val[2]};
        default:              busRdata_reg <= '0;
      endcase
    end else begin
      busRdata_reg <= '0;
    end
  end

  assign busRdata  = busRdata_reg;
  assign rollOut   = rollOut_reg;
  assign peakOut   = peak_reg;
  assign rollValid = rollValid_reg;

  property p_sub_len;
    @(posedge core_clk) disable iff (!arst_n) subEnd && !restartRoll |=> minCnt_reg == '0 && tickCnt_reg == '0;
  endproperty
  a_sub_len: assert property (p_sub_len) else $error("sub-period end did not rewind the time base");

  property p_fill_max;
    @(posedge core_clk) disable iff (!arst_n) fill_reg <= nSub_reg && ptr_reg < nSub_reg;
  endproperty
  a_fill_max: assert property (p_fill_max) else $error("window fill or pointer beyond configured count");

  property p_no_early;
    @(posedge core_clk) disable iff (!arst_n)
      !rollValid_reg |-> (rollOut_reg == '0 && state_reg != ST_ROLL) || fillsNow;
  endproperty
  a_no_early: assert property (p_no_early) else $error("rolling result shown before window filled");

  property p_slide;
    @(posedge core_clk) disable iff (!arst_n) state_reg == ST_UPD && fillsNow && !restartRoll
      |=> state_reg == ST_ROLL ##[40:41] rollValid_reg;
  endproperty
  a_slide: assert property (p_slide) else $error("rolling value not recomputed after sub-period");

  property p_restart;
    @(posedge core_clk) disable iff (!arst_n)
      keyEdge || remoteReset |=> fill_reg == '0 && !rollValid_reg && peak_reg == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("reset command did not restart the calculation");

  property p_cfg;
    @(posedge core_clk) disable iff (!arst_n) ctrlOk && (newN != nSub_reg || newMin != subMin_reg)
      |=> fill_reg == '0 && state_reg == ST_IDLE && !rollValid_reg;
  endproperty
  a_cfg: assert property (p_cfg) else $error("setting change did not restart rolling demand");

  property p_peak_clr;
    @(posedge core_clk) disable iff (!arst_n) minChange |=> peak_reg == '0 && subMin_reg == $past(newMin);
  endproperty
  a_peak_clr: assert property (p_peak_clr) else $error("sub-period change did not clear peak");

  property p_peak_nv;
    @(posedge core_clk) disable iff (!arst_n) !restored_reg && !clearPeak |=> peak_reg == $past(nvPeak);
  endproperty
  a_peak_nv: assert property (p_peak_nv) else $error("peak not restored from backing store");

  property p_tick;
    @(posedge core_clk) disable iff (!arst_n) restartRoll |=> tickCnt_reg == '0 && minCnt_reg == '0;
  endproperty
  a_tick: assert property (p_tick) else $error("time base not restarted with calculation");
endmodule

/* File: rolling_peak_demand_tb_top.sv */
// Self-checking bench for the rolling and peak demand block
`timescale 1ns/1ns
`include "rpd_defs.svh"
module rolling_peak_demand_tb_top
  import rpd_pkg::*;
;
  localparam int P = 100;
  logic        core_clk, arst_n, busWr, busRd, keyReset, hold, slow, rdSeen, mValid;
  logic [7:0]  busAddr;
  logic [31:0] busWdata, busRdata, seed;
  logic [48:0] lastRoll, lastPeak;
  rpd_rms_t    rmsIn;
  rpd_demand_t nvPeak, rollOut, peakOut, level, mPeak, mRoll;
  logic        rollValid;
  rpd_demand_t winQ[$];
  logic [48:0] rollQ[$], peakQ[$];
  logic [31:0] rdQ[$];
  int          subMin, nSub, t0, cyc, errors, samples_checked;

  rolling_peak_demand #(.MIN_CYC(P)) u_dut (.core_clk(core_clk), .arst_n(arst_n), .busAddr(busAddr),
    .busWdata(busWdata), .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .rmsIn(rmsIn),
    .keyReset(keyReset), .nvPeak(nvPeak), .rollOut(rollOut), .peakOut(peakOut), .rollValid(rollValid));
  rpd_rms_source u_src (.core_clk(core_clk), .arst_n(arst_n), .hold(hold), .slow(slow), .level(level),
    .rmsOut(rmsIn));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(string what, logic [48:0] seen, logic [48:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      $display("Error timeout expected finish seen hang");
      test_done();
    end
  end

  // Output watcher: each visible change consumes the oldest note
  always @(posedge core_clk) begin
    rdSeen = busRd;
    #1;
    if (!arst_n) begin
      lastRoll = '0;
      lastPeak = '0;
    end else begin
      if (rdSeen) check("busRdata", busRdata, rdQ.size() ? rdQ.pop_front() : 'x);
      if ({rollValid, rollOut} !== lastRoll) begin
        lastRoll = {rollValid, rollOut};
        check("rollOut", lastRoll, rollQ.size() ? rollQ.pop_front() : 'x);
      end
      if ({1'b0, peakOut} !== lastPeak) begin
        lastPeak = {1'b0, peakOut};
        check("peakOut", lastPeak, peakQ.size() ? peakQ.pop_front() : 'x);
      end
    end
  end

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    busAddr  <= a;
    busWdata <= d;
    busWr    <= 1'b1;
    @(posedge core_clk);
    busWr    <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge core_clk);
    busAddr <= a;
    busRd   <= 1'b1;
    rdQ.push_back(e);
    @(posedge core_clk);
    busRd   <= 1'b0;
  endtask

  task automatic expRoll(logic v, rpd_demand_t r);
    if ({v, r} !== {mValid, mRoll}) rollQ.push_back({v, r});
    mValid = v;
    mRoll  = r;
  endtask

  task automatic expPeak(rpd_demand_t p);
    if (p !== mPeak) peakQ.push_back({1'b0, p});
    mPeak = p;
  endtask

  task automatic newLevel();
    rpd_demand_t n;
    for (int p = 0; p < 3; p++) n.val[p] = 16'(xs());
    level <= n;
  endtask

  task automatic waitTo(int c);
    while (cyc < c) @(posedge core_clk);
  endtask

  // Restart by CTRL write, CMD write or the front key; clr says whether peaks are cleared
  task automatic restart(int how, logic [31:0] d, logic clr);
    @(posedge core_clk);
    hold <= 1'b1;
    repeat (2) @(posedge core_clk);
    if (how == 2) begin
      keyReset <= 1'b1;
      // Two sync stages and the edge stage put the restart three edges after the pin
      t0 = cyc + 3;
    end else begin
      wr(how ? `RPD_OFF_CMD : `RPD_OFF_CTRL, d);
      t0 = cyc;
    end
    winQ.delete();
    expRoll(1'b0, '0);
    if (clr) expPeak('0);
    newLevel();
    repeat (6) @(posedge core_clk);
    keyReset <= 1'b0;
    hold     <= 1'b0;
  endtask

  task automatic runSubs(int k0, int k1);
    rpd_demand_t pk, r;
    int s;
    for (int k = k0; k <= k1; k++) begin
      waitTo(t0 + k * P * subMin - 6);
      hold <= 1'b1;
      waitTo(t0 + k * P * subMin + 6);
      pk = mPeak;
      for (int p = 0; p < 3; p++) if (level.val[p] > pk.val[p]) pk.val[p] = level.val[p];
      expPeak(pk);
      winQ.push_back(level);
      if (winQ.size() > nSub) void'(winQ.pop_front());
      if (winQ.size() == nSub) begin
        for (int p = 0; p < 3; p++) begin
          s = 0;
          foreach (winQ[i]) s += winQ[i].val[p];
          r.val[p] = 16'(s / nSub);
        end
        expRoll(1'b1, r);
      end
      newLevel();
      hold <= 1'b0;
    end
    repeat (84) @(posedge core_clk);
  endtask

  initial begin
    seed = 32'h9d94;
    {arst_n, busWr, busRd, keyReset, slow, mValid} = '0;
    {busAddr, busWdata, level, mPeak, mRoll, lastRoll, lastPeak} = '0;
    {cyc, errors, samples_checked} = '0;
    hold   = 1'b1;
    nvPeak = 48'({xs(), xs()});
    subMin = 1;
    nSub   = 1;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    expPeak(nvPeak);
    rd(`RPD_OFF_CTRL, 32'h0000_0101);
    rd(8'hfc, 32'h0);
    wr(`RPD_OFF_CTRL, 32'h0000_1901);
    wr(`RPD_OFF_CTRL, 32'h0000_0001);
    wr(`RPD_OFF_CTRL, 32'h0000_013d);
    wr(`RPD_OFF_CTRL, 32'h0000_0100);
    rd(`RPD_OFF_CTRL, 32'h0000_0101);
    $display("test registers done");
    nSub = 3;
    restart(0, 32'h0000_0301, 1'b0);
    runSubs(1, 2);
    slow <= 1'b1;
    runSubs(3, 5);
    rd(`RPD_OFF_STATUS, 32'h0000_0301);
    for (int p = 0; p < 3; p++) rd(`RPD_OFF_ROLL_A + 8'(4 * p), {16'h0, mRoll.val[p]});
    $display("test window done");
    restart(1, 32'h1, 1'b1);
    runSubs(1, 3);
    slow <= 1'b0;
    nSub = 1;
    restart(0, 32'h0000_0101, 1'b0);
    restart(2, 32'h0, 1'b1);
    runSubs(1, 2);
    $display("test resets done");
    subMin = 2;
    nSub   = 2;
    restart(0, 32'h0000_0202, 1'b1);
    runSubs(1, 3);
    $display("test sub period length done");
    nvPeak <= mPeak;
    arst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    {mValid, mRoll, mPeak} = '0;
    winQ.delete();
    subMin = 1;
    nSub   = 1;
    arst_n <= 1'b1;
    expPeak(nvPeak);
    t0 = cyc;
    runSubs(1, 2);
    for (int p = 0; p < 3; p++) rd(`RPD_OFF_PEAK_A + 8'(4 * p), {16'h0, mPeak.val[p]});
    $display("test power loss done");
    test_done();
  end
endmodule

/* File: rpd_defs.svh */
// Constants for the rolling and peak demand block
`ifndef RPD_DEFS_SVH
`define RPD_DEFS_SVH

`define RPD_RMS_W        16
`define RPD_CNT_W        24
`define RPD_NSUB_W       5
`define RPD_MIN_W        6
`define RPD_NSUB_MAX     24
`define RPD_SUBMIN_MAX   60
`define RPD_CLK_HZ       20000000
`define RPD_MINUTE_S     60
`define RPD_MIN_CYC      (`RPD_MINUTE_S * `RPD_CLK_HZ)

`define RPD_OFF_CTRL     8'h00
`define RPD_OFF_CMD      8'h04
`define RPD_OFF_STATUS   8'h08
`define RPD_OFF_ROLL_A   8'h0c
`define RPD_OFF_PEAK_A   8'h18

`define RPD_CTRL_MIN_LSB 0
`define RPD_CTRL_N_LSB   8
`define RPD_CMD_RESET    0
`define RPD_ST_VALID     0
`define RPD_ST_BUSY      1
`define RPD_ST_FILL_LSB  8

`define RPD_RST_SUBMIN   6'h01
`define RPD_RST_NSUB     5'h01

`endif

/* File: rpd_divider.sv */
// Serial restoring unsigned divider, one quotient bit per cycle
`timescale 1ns/1ns
module rpd_divider #(
  parameter int NW = 40,
  parameter int DW = 24
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  output logic               busy,
  output logic               done,
  output logic [NW-1:0]      quo
);
  localparam int CW = $clog2(NW + 1);

  logic [DW:0]   rem_reg;
  logic [DW-1:0] den_reg;
  logic [NW-1:0] quo_reg;
  logic [CW-1:0] cnt_reg;
  logic          busy_reg;
  logic          done_reg;
  logic [DW:0]   remSh;
  logic          fits;

  assign remSh = {rem_reg[DW-1:0], quo_reg[NW-1]};
  assign fits  = remSh >= {1'b0, den_reg};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rem_reg  <= '0;
      den_reg  <= '0;
      quo_reg  <= '0;
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start) begin
        rem_reg  <= '0;
        den_reg  <= den;
        quo_reg  <= num;
        cnt_reg  <= CW'(NW);
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        rem_reg  <= fits ? remSh - {1'b0, den_reg} : remSh;
        quo_reg  <= {quo_reg[NW-2:0], fits};
        cnt_reg  <= cnt_reg - CW'(1);
        if (cnt_reg == CW'(1)) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
  assign quo  = quo_reg;
endmodule

/* File: rpd_pkg.sv */
// Types shared by the rolling and peak demand block
`include "rpd_defs.svh"
package rpd_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_AVG  = 2'b01,
    ST_UPD  = 2'b10,
    ST_ROLL = 2'b11
  } rpd_state_t;

  typedef struct packed {
    logic                            valid;
    logic [2:0][`RPD_RMS_W-1:0]      phaseCurrent;
  } rpd_rms_t;

  typedef struct packed {
    logic [2:0][`RPD_RMS_W-1:0]      val;
  } rpd_demand_t;
endpackage

/* File: rpd_rms_source.sv */
// Phase current RMS source feeding the demand block
`timescale 1ns/1ns
module rpd_rms_source
  import rpd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        hold,
  input  wire logic        slow,
  input  wire rpd_demand_t level,
  output rpd_rms_t         rmsOut
);
  logic [1:0] phaseCnt_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      phaseCnt_reg <= 2'h0;
      rmsOut       <= '0;
    end else begin
      phaseCnt_reg <= (phaseCnt_reg == 2'h2) ? 2'h0 : phaseCnt_reg + 2'h1;
      // Slow mode sends one sample in three
      if (!hold && (!slow || phaseCnt_reg == 2'h0)) begin
        rmsOut.valid        <= 1'b1;
        rmsOut.phaseCurrent <= level.val;
      end else begin
        // Idle cycles carry junk that flips every cycle, so every second idle cycle carries the last sample again
        rmsOut.valid        <= 1'b0;
        rmsOut.phaseCurrent <= ~rmsOut.phaseCurrent;
      end
    end
  end
endmodule
